// ---- wum_pkg.sv ----
// Shared constants and types for the wiper update and mute controller
package wum_pkg;
   // System clock and time units
   localparam int unsigned CLK_HZ        = 10_000_000;
   localparam int unsigned MS_PER_S      = 1000;
   localparam int unsigned CYCLES_PER_MS = CLK_HZ / MS_PER_S;

   // Intervals, all in milliseconds
   localparam int unsigned ZC_WINDOW_MS  = 50;
   localparam int unsigned REPEAT_MS     = 100;
   localparam int unsigned HOLD_FIRST_MS = 1000;
   localparam int unsigned DEBOUNCE_MS   = 5;

   // Serial word layout
   localparam int unsigned WORD_BITS = 16;
   localparam int unsigned HALF_BITS = 8;
   localparam int unsigned POS_BITS  = 6;
   localparam int unsigned MUTE_BIT  = 6;
   localparam int unsigned NPOT      = 2;
   localparam logic [5:0]  POS_MAX   = 6'h3F;
   localparam logic [5:0]  POS_MIN   = 6'h00;

   // Debounced input slots
   localparam int unsigned BTN_VU   = 0;
   localparam int unsigned BTN_VD   = 1;
   localparam int unsigned BTN_UP0  = 2;
   localparam int unsigned BTN_UP1  = 3;
   localparam int unsigned BTN_DN0  = 4;
   localparam int unsigned BTN_DN1  = 5;
   localparam int unsigned BTN_MUTE = 6;
   localparam int unsigned N_DB     = 7;

   // Register map
   localparam logic [31:0] ADDR_CTRL   = 32'h0000_0000;
   localparam logic [31:0] ADDR_STATUS = 32'h0000_0004;
   localparam logic        CTRL_RESET  = 1'b1;
   localparam int unsigned CTRL_BTN_EN = 0;
   localparam int unsigned ST_POS0     = 0;
   localparam int unsigned ST_POS1     = 8;
   localparam int unsigned ST_HWMUTE   = 16;
   localparam int unsigned ST_PEND     = 17;
   localparam int unsigned ST_BUSY     = 19;
   localparam int unsigned ST_BYPASS   = 20;
   localparam logic        HRESP_OKAY  = 1'b0;

   // One potentiometer's applied or pending setting
   typedef struct packed {
      logic       mute;
      logic [5:0] pos;
   } wum_pot_t;

   // Pushbutton auto-repeat phases
   typedef enum logic [1:0] {
      REP_IDLE,
      REP_FIRST,
      REP_REPEAT
   } wum_rep_t;
endpackage

// ---- wum_top.sv ----
// Wiper update gating, mute control and AHB-Lite status port
//
// Operation
// - Serial change waits for zero-cross, per pot
// - Force update when 50 ms window expires
// - Enable pin high bypasses zero-cross and timeout
// - Button step waits zero-cross or 50 ms
// - Held button: one step, second after 1 s, then every 100 ms
// - Hardware mute sends both wipers low
// - Mute input toggles mute on and off
// - Any button press cancels hardware mute when steps are allowed
// - Mute input debounced like the buttons
// - Power up unmuted; first mute press mutes
// - Serial bits 6 and 14 mute each pot
// - Serial port beats pushbuttons
// - No button steps during serial activity
// - Bits 0-5 and 8-13 give position; 7, 15 ignored
// - Word taken when strobe falls after 16 bits
`timescale 1ns/1ps
module wum_top
   import wum_pkg::*;
#(
   parameter int unsigned MS_CYCLES   = wum_pkg::CYCLES_PER_MS,
   parameter int unsigned DEBOUNCE_T  = wum_pkg::DEBOUNCE_MS
) (
   input  wire logic                    hclk,
   input  wire logic                    hresetn,
   input  wire logic                    hsel,
   input  wire logic [31:0]             haddr,
   input  wire logic [1:0]              htrans,
   input  wire logic                    hwrite,
   input  wire logic [2:0]              hsize,
   input  wire logic [31:0]             hwdata,
   input  wire logic                    hready,
   output logic                         hreadyout,
   output logic                         hresp,
   output logic [31:0]                  hrdata,
   input  wire logic                    serial_clk,
   input  wire logic                    serial_strobe,
   input  wire logic                    serial_data,
   input  wire logic                    zero_cross_enable,
   input  wire logic [1:0]              zero_cross,
   input  wire logic                    mute_button_n,
   input  wire logic                    volume_up_button_n,
   input  wire logic                    volume_down_button_n,
   input  wire logic                    up_button_pot0_n,
   input  wire logic                    up_button_pot1_n,
   input  wire logic                    down_button_pot0_n,
   input  wire logic                    down_button_pot1_n,
   output wum_pkg::wum_pot_t [1:0]      wiper,
   output logic [1:0]                   wiper_to_low
);
   import wum_pkg::*;

   localparam int unsigned NSYNC = N_DB + 4;

   // Refuse settings the counters cannot hold
   if (MS_CYCLES < 2 || MS_CYCLES > 65535) begin : g_bad_ms
      $error("MS_CYCLES out of range");
   end
   if (DEBOUNCE_T < 1 || DEBOUNCE_T > 15) begin : g_bad_db
      $error("DEBOUNCE_T out of range");
   end

   // ---------------- Serial link domain ----------------
   logic [WORD_BITS-1:0] shift_q;
   logic [4:0]           bits_q;
   logic                 armed_q;
   logic                 arm_rst_n;

   // Strobe low rearms the bit count without needing a clock edge
   assign arm_rst_n = serial_strobe & hresetn;

   always_ff @(posedge serial_clk or negedge arm_rst_n) begin
      if (!arm_rst_n) begin
         armed_q <= 1'b1;
      end else begin
         armed_q <= 1'b0;
      end
   end

   // LSB first: first bit ends up at bit 0 after a full word
   always_ff @(posedge serial_clk or negedge hresetn) begin
      if (!hresetn) begin
         shift_q <= '0;
      end else begin
         shift_q <= {serial_data, shift_q[WORD_BITS-1:1]};
      end
   end

   // Saturating count; stays frozen after the strobe falls
   always_ff @(posedge serial_clk or negedge hresetn) begin
      if (!hresetn) begin
         bits_q <= '0;
      end else if (armed_q) begin
         bits_q <= 5'h01;
      end else if (bits_q != 5'(WORD_BITS)) begin
         bits_q <= bits_q + 5'h01;
      end
   end

   // ---------------- Input synchronisers ----------------
   logic [NSYNC-1:0] async_in;
   logic [NSYNC-1:0] s1_q;
   logic [NSYNC-1:0] s2_q;

   assign async_in = {serial_strobe, zero_cross_enable, zero_cross,
                      mute_button_n, down_button_pot1_n,
                      down_button_pot0_n, up_button_pot1_n,
                      up_button_pot0_n, volume_down_button_n,
                      volume_up_button_n};

   // Two flops on every pin; only the second stage is read
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s1_q <= {1'b0, 1'b0, 2'b00, {N_DB{1'b1}}};
         s2_q <= {1'b0, 1'b0, 2'b00, {N_DB{1'b1}}};
      end else begin
         s1_q <= async_in;
         s2_q <= s1_q;
      end
   end

   logic       strobe_s;
   logic       bypass_s;
   logic [1:0] zc_s;
   assign strobe_s = s2_q[N_DB+3];
   assign bypass_s = s2_q[N_DB+2];
   assign zc_s     = s2_q[N_DB+1:N_DB];

   // ---------------- Millisecond timebase ----------------
   logic [15:0] pre_q;
   logic        ms_tick;

   // Free-running, independent of the serial clock
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pre_q <= '0;
      end else if (pre_q == 16'(MS_CYCLES - 1)) begin
         pre_q <= '0;
      end else begin
         pre_q <= pre_q + 16'h0001;
      end
   end
   assign ms_tick = (pre_q == 16'(MS_CYCLES - 1));

   // ---------------- Debouncers ----------------
   logic [N_DB-1:0] db_q;
   logic [N_DB-1:0] pressed;

   // Buttons and mute share one filter
   for (genvar g = 0; g < N_DB; g++) begin : g_db
      logic [3:0] cnt_q;
      always_ff @(posedge hclk or negedge hresetn) begin
         if (!hresetn) begin
            cnt_q   <= '0;
            db_q[g] <= 1'b1;
         end else if (s2_q[g] == db_q[g]) begin
            cnt_q <= '0;
         end else if (ms_tick) begin
            if (cnt_q == 4'(DEBOUNCE_T - 1)) begin
               cnt_q   <= '0;
               db_q[g] <= s2_q[g];
            end else begin
               cnt_q <= cnt_q + 4'h1;
            end
         end
      end
   end
   assign pressed = ~db_q;

   // ---------------- Serial word capture ----------------
   logic strobe_d_q;
   logic serial_load;
   logic serial_busy;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         strobe_d_q <= 1'b0;
      end else begin
         strobe_d_q <= strobe_s;
      end
   end

   // Arm flag crosses through two flops; read only when settled
   logic arm_s1_q;
   logic arm_s2_q;
   logic clk_seen_q;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         arm_s1_q <= 1'b1;
         arm_s2_q <= 1'b1;
      end else begin
         arm_s1_q <= armed_q;
         arm_s2_q <= arm_s1_q;
      end
   end

   // A frame with no clocks must not reload the previous word
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         clk_seen_q <= 1'b0;
      end else if (strobe_s && !strobe_d_q) begin
         clk_seen_q <= ~arm_s2_q;
      end else if (strobe_s) begin
         clk_seen_q <= clk_seen_q | ~arm_s2_q;
      end
   end

   // Shift data and count are quiet once the strobe is low
   assign serial_load = strobe_d_q & ~strobe_s & clk_seen_q &
                        (bits_q == 5'(WORD_BITS));
   assign serial_busy = strobe_s | strobe_d_q;

   wum_pot_t [1:0] word_pot;
   for (genvar p = 0; p < NPOT; p++) begin : g_word
      // Bit 7 of each half is dropped
      assign word_pot[p].pos  = shift_q[p*HALF_BITS +: POS_BITS];
      assign word_pot[p].mute = shift_q[p*HALF_BITS + MUTE_BIT];
   end

   // ---------------- Control register ----------------
   logic ctrl_btn_en_q;
   logic btn_ok;

   // Steps need software consent and an idle serial port
   assign btn_ok = ctrl_btn_en_q & ~serial_busy;

   // ---------------- Pushbutton auto-repeat ----------------
   wum_rep_t    rep_q;
   logic [9:0]  hold_q;
   logic        any_btn;
   logic        step;
   logic [N_DB-1:0] pressed_d_q;
   logic        new_press;

   assign any_btn   = |pressed[BTN_DN1:BTN_VU];
   assign new_press = |(pressed[BTN_DN1:BTN_VU] & ~pressed_d_q[BTN_DN1:BTN_VU]);

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pressed_d_q <= '0;
      end else begin
         pressed_d_q <= pressed;
      end
   end

   // First step on press, second after 1 s, then every 100 ms
   always_comb begin
      step = 1'b0;
      case (rep_q)
         REP_IDLE:   step = any_btn;
         REP_FIRST:  step = ms_tick & (hold_q == 10'(HOLD_FIRST_MS - 1));
         REP_REPEAT: step = ms_tick & (hold_q == 10'(REPEAT_MS - 1));
         default:    step = 1'b0;
      endcase
      step = step & any_btn & btn_ok;
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rep_q  <= REP_IDLE;
         hold_q <= '0;
      end else if (!any_btn || !btn_ok) begin
         rep_q  <= REP_IDLE;
         hold_q <= '0;
      end else begin
         case (rep_q)
            REP_IDLE: begin
               rep_q  <= REP_FIRST;
               hold_q <= '0;
            end
            REP_FIRST, REP_REPEAT: begin
               if (step) begin
                  rep_q  <= REP_REPEAT;
                  hold_q <= '0;
               end else if (ms_tick) begin
                  hold_q <= hold_q + 10'h001;
               end
            end
            default: begin
               rep_q  <= REP_IDLE;
               hold_q <= '0;
            end
         endcase
      end
   end

   // ---------------- Hardware mute toggle ----------------
   logic hw_mute_q;
   logic mute_prev_q;
   logic mute_edge;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         mute_prev_q <= 1'b0;
      end else begin
         mute_prev_q <= pressed[BTN_MUTE];
      end
   end
   assign mute_edge = pressed[BTN_MUTE] & ~mute_prev_q;

   // Starts released; a toggle in the cancel cycle still counts
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hw_mute_q <= 1'b0;
      end else if (mute_edge) begin
         hw_mute_q <= ~hw_mute_q;
      end else if (new_press && btn_ok) begin
         hw_mute_q <= 1'b0;
      end
   end

   // ---------------- Per-pot update gating ----------------
   wum_pot_t [1:0] wiper_q;
   wum_pot_t [1:0] target_q;
   logic [1:0]     pending_q;
   logic [1:0]     to_low_q;
   logic [1:0]     up_req;
   logic [1:0]     dn_req;

   assign up_req[0] = pressed[BTN_VU] | pressed[BTN_UP0];
   assign up_req[1] = pressed[BTN_VU] | pressed[BTN_UP1];
   assign dn_req[0] = pressed[BTN_VD] | pressed[BTN_DN0];
   assign dn_req[1] = pressed[BTN_VD] | pressed[BTN_DN1];

   for (genvar p = 0; p < NPOT; p++) begin : g_pot
      logic [5:0] timer_q;
      wum_pot_t   base;
      wum_pot_t   stepped;
      logic       btn_step;
      logic       apply;

      // Steps build on a pending value so quick presses add up
      assign base = pending_q[p] ? target_q[p] : wiper_q[p];

      always_comb begin
         stepped  = base;
         btn_step = 1'b0;
         if (up_req[p] && !dn_req[p] && base.pos != POS_MAX) begin
            stepped.pos = base.pos + 6'h01;
            btn_step    = step;
         end else if (dn_req[p] && !up_req[p] && base.pos != POS_MIN) begin
            stepped.pos = base.pos - 6'h01;
            btn_step    = step;
         end
      end

      // Zero-cross, timeout, or bypass by the enable pin
      assign apply = pending_q[p] &
                     (bypass_s |
                      zc_s[p] |
                      (timer_q == 6'(ZC_WINDOW_MS)));

      // Serial load overrides any button step in the same cycle
      always_ff @(posedge hclk or negedge hresetn) begin
         if (!hresetn) begin
            pending_q[p] <= 1'b0;
            target_q[p]  <= '0;
         end else if (serial_load) begin
            pending_q[p] <= 1'b1;
            target_q[p]  <= word_pot[p];
         end else if (btn_step) begin
            pending_q[p] <= 1'b1;
            target_q[p]  <= stepped;
         end else if (apply) begin
            pending_q[p] <= 1'b0;
         end
      end

      // Window restarts with each new request
      always_ff @(posedge hclk or negedge hresetn) begin
         if (!hresetn) begin
            timer_q <= '0;
         end else if (serial_load || btn_step || !pending_q[p]) begin
            timer_q <= '0;
         end else if (ms_tick && timer_q != 6'(ZC_WINDOW_MS)) begin
            timer_q <= timer_q + 6'h01;
         end
      end

      // Applied setting; a fresh load in the same cycle waits its turn
      always_ff @(posedge hclk or negedge hresetn) begin
         if (!hresetn) begin
            wiper_q[p] <= '0;
         end else if (apply && !serial_load && !btn_step) begin
            wiper_q[p] <= target_q[p];
         end
      end

      // Either mute source grounds the wiper; position is kept
      always_ff @(posedge hclk or negedge hresetn) begin
         if (!hresetn) begin
            to_low_q[p] <= 1'b0;
         end else begin
            to_low_q[p] <= wiper_q[p].mute | hw_mute_q;
         end
      end
   end

   assign wiper        = wiper_q;
   assign wiper_to_low = to_low_q;

   // ---------------- AHB-Lite slave ----------------
   logic        dwr_q;
   logic [31:0] daddr_q;
   logic [31:0] hrdata_q;
   logic [31:0] status;
   logic        addr_phase;

   // Single-cycle slave: never stalls, always OKAY
   assign hreadyout  = 1'b1;
   assign hresp      = HRESP_OKAY;
   assign addr_phase = hsel & hready & htrans[1];

   always_comb begin
      status = '0;
      status[ST_POS0 +: POS_BITS]  = wiper_q[0].pos;
      status[ST_POS0 + MUTE_BIT]   = wiper_q[0].mute;
      status[ST_POS1 +: POS_BITS]  = wiper_q[1].pos;
      status[ST_POS1 + MUTE_BIT]   = wiper_q[1].mute;
      status[ST_HWMUTE]            = hw_mute_q;
      status[ST_PEND +: NPOT]      = pending_q;
      status[ST_BUSY]              = serial_busy;
      status[ST_BYPASS]            = bypass_s;
   end

   // Address phase capture; read data lands for the data phase
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dwr_q    <= 1'b0;
         daddr_q  <= '0;
         hrdata_q <= '0;
      end else begin
         dwr_q   <= addr_phase & hwrite;
         daddr_q <= haddr;
         if (addr_phase && !hwrite && haddr == ADDR_STATUS) begin
            hrdata_q <= status;
         end else if (addr_phase && !hwrite && haddr == ADDR_CTRL) begin
            hrdata_q <= {31'h0000_0000, ctrl_btn_en_q};
         end else begin
            hrdata_q <= '0;
         end
      end
   end
   assign hrdata = hrdata_q;

   // Control write in the data phase; other offsets ignored
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl_btn_en_q <= CTRL_RESET;
      end else if (dwr_q && daddr_q == ADDR_CTRL) begin
         ctrl_btn_en_q <= hwdata[CTRL_BTN_EN];
      end
   end

endmodule

// ---- wum_ctrl_model.sv ----
// Controller model driving the three-wire serial port
`timescale 1ns/1ps
module wum_ctrl_model (
   output logic serial_clk,
   output logic serial_strobe,
   output logic serial_data
);
   // Link idle: clock stands low, strobe low
   initial begin
      serial_clk = 1'b0;
      serial_strobe = 1'b0;
      serial_data = 1'b0;
   end
   // One frame, bit 0 first; clock runs only inside it
   task automatic send(input logic [15:0] w, input int n, input int hold_ns);
      serial_strobe = 1'b1;
      #50;
      for (int i = 0; i < n; i++) begin
         serial_data = w[i];
         #32;
         serial_clk = 1'b1;
         #32;
         serial_clk = 1'b0;
      end
      // Released line shows no stale bit
      serial_data = ~serial_data;
      #(hold_ns + 50);
      serial_strobe = 1'b0;
      #250;
   endtask
endmodule

// ---- wum_top_checker.sv ----
// Port assertions for the wiper update and mute controller
`timescale 1ns/1ps
module wum_checker
   import wum_pkg::*;
(
   input wire logic                hclk,
   input wire logic                hresetn,
   input wire logic                hsel,
   input wire logic [1:0]          htrans,
   input wire logic                hwrite,
   input wire logic                hready,
   input wire logic                hreadyout,
   input wire logic                hresp,
   input wire logic [31:0]         hrdata,
   input wire logic                serial_strobe,
   input wire logic                zero_cross_enable,
   input wire wum_pkg::wum_pot_t [1:0] wiper,
   input wire logic [1:0]          wiper_to_low
);
   // Strobe is sampled raw; long repeats hide its sync delay
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   ready_hi_a: assert property (hreadyout)
      else $error("hreadyout dropped");
   resp_okay_a: assert property (hresp == HRESP_OKAY)
      else $error("error response seen");
   rdata_idle_a: assert property (!(hsel && hready && htrans[1] && !hwrite)
      |=> hrdata == 32'h0) else $error("read data outside data phase");
   reset_val_a: assert property ($rose(hresetn) |-> wiper_to_low == 2'h0)
      else $error("muted after reset");
   serial_block_a: assert property ((zero_cross_enable && serial_strobe) [*8]
      |-> $stable(wiper)) else $error("wiper moved during a frame");
   early_apply_a: assert property ((zero_cross_enable && serial_strobe) [*8]
      ##1 !serial_strobe |-> $stable(wiper) [*2]) else $error("word taken early");
   soft_mute_a: assert property ($rose(wiper[0].mute) |=> wiper_to_low[0])
      else $error("soft mute not applied");
   mute_diff_a: assert property (wiper_to_low[1] && !wiper_to_low[0]
      |-> $past(wiper[1].mute)) else $error("one pot muted without its bit");
   hw_both_a: assert property ($rose(wiper_to_low[0]) && !$past(wiper[0].mute)
      |-> wiper_to_low[1]) else $error("hardware mute hit one pot");

   cover property ($rose(&wiper_to_low));
   cover property ($fell(serial_strobe) && !zero_cross_enable);
   cover property ($changed(wiper) && !zero_cross_enable);
endmodule

bind wum_top wum_checker u_chk (.hclk, .hresetn, .hsel, .htrans, .hwrite, .hready,
   .hreadyout, .hresp, .hrdata, .serial_strobe, .zero_cross_enable, .wiper,
   .wiper_to_low);

// ---- wiper_update_mute_control_bench.sv ----
// Self-checking bench for the wiper update and mute controller
`timescale 1ns/1ps
module wiper_update_mute_control_bench;
   import wum_pkg::*;
   logic           hclk, hresetn, hsel, hwrite, zce, hreadyout, hresp;
   logic           s_clk, s_stb, s_dat;
   logic [31:0]    haddr, hwdata, hrdata, rd;
   logic [2:0]     hsize;
   logic [1:0]     htrans, zc, wtl;
   logic [6:0]     btn_n;
   wum_pot_t [1:0] wiper;
   int             fails, n_compared, cycles;

   wum_top #(.MS_CYCLES(10), .DEBOUNCE_T(2)) dut (.hclk(hclk), .hresetn(hresetn),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
      .hrdata(hrdata), .serial_clk(s_clk), .serial_strobe(s_stb),
      .serial_data(s_dat), .zero_cross_enable(zce), .zero_cross(zc),
      .mute_button_n(btn_n[BTN_MUTE]), .volume_up_button_n(btn_n[BTN_VU]),
      .volume_down_button_n(btn_n[BTN_VD]), .up_button_pot0_n(btn_n[BTN_UP0]),
      .up_button_pot1_n(btn_n[BTN_UP1]), .down_button_pot0_n(btn_n[BTN_DN0]),
      .down_button_pot1_n(btn_n[BTN_DN1]), .wiper(wiper), .wiper_to_low(wtl));
   wum_ctrl_model m (.serial_clk(s_clk), .serial_strobe(s_stb), .serial_data(s_dat));

   // 10 MHz bus clock
   initial begin
      hclk = 1'b0;
      forever #50 hclk = ~hclk;
   end

   task automatic results();
      $display("compared %0d, mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         fails++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge hclk);
   endtask
   // Single transfer; read data taken at the data-phase ready edge
   task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd);
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= wr;
      htrans <= 2'h2;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      htrans <= 2'h0;
      hsel <= 1'b0;
      hwdata <= wd;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      rd = hrdata;
   endtask
   task automatic press(input int b, input int n);
      @(posedge hclk);
      btn_n[b] <= 1'b0;
      cyc(n);
      btn_n[b] <= 1'b1;
      cyc(60);
   endtask

   task automatic t_bypass();
      @(posedge hclk);
      zce <= 1'b1;
      cyc(5);
      m.send(16'h8A95, 16, 0);
      cyc(8);
      @(negedge hclk);
      chk(32'(wiper), 32'({7'h0A, 7'h15}));
      ahb(1'b0, ADDR_STATUS, 32'h0);
      chk(rd, 32'h0010_0A15);
      ahb(1'b0, 32'h0000_0040, 32'h0);
      chk(rd, 32'h0);
      m.send(16'h3F3F, 12, 0);
      cyc(10);
      @(negedge hclk);
      chk(32'(wiper), 32'({7'h0A, 7'h15}));
      $display("test bypass done");
   endtask
   task automatic t_soft();
      logic [15:0] w [3] = '{16'h0A55, 16'h4A15, 16'h0A15};
      logic [1:0]  e [3] = '{2'h1, 2'h2, 2'h0};
      for (int i = 0; i < 3; i++) begin
         m.send(w[i], 16, 0);
         cyc(8);
         @(negedge hclk);
         chk(32'(wtl), 32'(e[i]));
      end
      $display("test soft mute done");
   endtask
   task automatic t_zc();
      int n;
      @(posedge hclk);
      zce <= 1'b0;
      cyc(5);
      m.send(16'h2030, 16, 0);
      cyc(100);
      @(negedge hclk);
      chk(32'(wiper), 32'({7'h0A, 7'h15}));
      @(posedge hclk);
      zc <= 2'h2;
      cyc(10);
      zc <= 2'h0;
      @(negedge hclk);
      chk(32'(wiper), 32'({7'h20, 7'h15}));
      for (n = 113; n < 700 && wiper[0].pos !== 6'h30; n++) @(negedge hclk);
      chk(32'(n >= 470 && n <= 530), 32'h1);
      $display("test zero cross done");
   endtask
   task automatic t_mute();
      press(BTN_MUTE, 50);
      @(negedge hclk);
      chk(32'(wtl), 32'h3);
      chk(32'(wiper), 32'({7'h20, 7'h30}));
      press(BTN_MUTE, 5);
      @(negedge hclk);
      chk(32'(wtl), 32'h3);
      press(BTN_MUTE, 50);
      @(negedge hclk);
      chk(32'(wtl), 32'h0);
      press(BTN_MUTE, 50);
      $display("test hardware mute done");
   endtask
   task automatic t_hold();
      @(posedge hclk);
      btn_n[BTN_UP0] <= 1'b0;
      cyc(300);
      @(negedge hclk);
      chk(32'(wtl), 32'h0);
      chk(32'(wiper[0]), 32'h30);
      cyc(400);
      @(negedge hclk);
      chk(32'(wiper[0]), 32'h31);
      cyc(8000);
      @(negedge hclk);
      chk(32'(wiper[0]), 32'h31);
      cyc(4000);
      btn_n[BTN_UP0] <= 1'b1;
      cyc(700);
      @(negedge hclk);
      chk(32'(wiper[0]), 32'h34);
      $display("test hold done");
   endtask
   task automatic t_ctrl();
      ahb(1'b0, ADDR_CTRL, 32'h0);
      chk(rd, 32'h1);
      ahb(1'b1, ADDR_CTRL, 32'h0);
      press(BTN_UP1, 100);
      cyc(600);
      @(negedge hclk);
      chk(32'(wiper[1]), 32'h20);
      ahb(1'b1, ADDR_CTRL, 32'h1);
      $display("test control done");
   endtask
   task automatic t_prio();
      @(posedge hclk);
      zce <= 1'b1;
      fork
         m.send(16'h0C0C, 16, 6000);
         press(BTN_DN1, 30);
      join
      cyc(700);
      @(negedge hclk);
      chk(32'(wiper), 32'({7'h0C, 7'h0C}));
      $display("test priority done");
   endtask

   // Hang guard
   always @(posedge hclk) begin
      cycles <= cycles + 1;
      if (cycles == 40000) begin
         fails++;
         results();
      end
   end

   initial begin
      hresetn = 1'b0;
      hsel = 1'b0;
      hwrite = 1'b0;
      haddr = 32'h0;
      hwdata = 32'h0;
      htrans = 2'h0;
      hsize = 3'h2;
      zce = 1'b1;
      zc = 2'h0;
      btn_n = 7'h7F;
      cyc(5);
      hresetn <= 1'b1;
      @(negedge hclk);
      chk(32'(wiper), 32'h0);
      chk(32'(wtl), 32'h0);
      t_bypass();
      t_soft();
      t_zc();
      t_mute();
      t_hold();
      t_ctrl();
      t_prio();
      results();
   end
endmodule
